/* File: rtl/bp_test_cfg_consts.svh */
// register indices, field positions, reset values of the channel test configuration bank
`ifndef BP_TEST_CFG_CONSTS_SVH
`define BP_TEST_CFG_CONSTS_SVH

// register indices; byte address on the bus is four times the index
`define IDX_OUT_MUX 18'h30009
`define IDX_MIN_THR 18'h3000A
`define IDX_MAX_THR 18'h3000B
`define IDX_TEST_CTL 18'h3000C
`define IDX_FIRST_INJ 18'h3000D
`define IDX_SECOND_INJ 18'h3000E
`define IDX_PAR_MASK 18'h3000F
`define IDX_INJ_CMD 18'h30100
`define IDX_ALARM_EN 18'h30101
`define IDX_ALIGN_FLAG 18'h30102
`define IDX_INT_MASK 18'h30103
`define IDX_PAR_FLAG 18'h30104
`define IDX_ALARM_RAW 18'h30105

// field positions
`define BIT_MUX_B01 6
`define BIT_MUX_B23 7
`define BIT_LOOP 4
`define BIT_PAR_EVEN 5
`define BIT_SCRAMBLE 6

// reset values
`define RST_OUT_MUX 8'hFF
`define RST_MIN_THR 5'h02
`define RST_MAX_THR 5'h0F
`define RST_TEST_CTL 8'h60
`define RST_INJ 8'h00
`define RST_SCR_SEED 7'h7F

`endif

/* File: rtl/bp_test_cfg_pkg.sv */
// types shared by the channel test configuration bank
package bp_test_cfg_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [7:0] chan_mask_t;
   typedef logic [4:0] fifo_level_t;
   typedef logic [3:0] burst_cnt_t;
   typedef logic [6:0] scr_state_t;
endpackage

/* File: rtl/backplane_channel_test_config.sv */
// channel test configuration registers with their datapath effects
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
`include "bp_test_cfg_consts.svh"
// Functional notes
// - B0 output takes B1 data when select 0
// - B2 output takes B3 data when select 0
// - per channel alarm on alignment threshold violation
// - one minimum threshold, range 1 to 23
// - enabled alarm latches per channel error flag
// - five bit maximum threshold, range 0 to 22
// - inject command replaces both framing bytes
// - four bit count of consecutive corrupted frames
// - loopback sends framed receive data to transmit
// - scramble enable gates descrambler and scrambler
// - programmable substitute for first framing byte
// - programmable substitute for second framing byte
// - mask inverts parity byte bits on transmit
module backplane_channel_test_config
   import bp_test_cfg_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   // classic wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [19:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irqOut,
   // receive side, after deserialization and framing
   input wire logic [63:0] rxFramedBus,
   input wire logic rxFrameStart,
   input wire logic [39:0] alignFifoLevel,
   // programmable logic parallel buses
   input wire logic [63:0] parallelChannelInBus,
   input wire logic [7:0] parallelChannelInParity,
   output logic [63:0] parallelChannelOutBus,
   output logic [7:0] parallelChannelOutParity,
   // transmit side, towards the serializer
   input wire logic txFrameStart,
   input wire logic txPosFirstFraming,
   input wire logic txPosSecondFraming,
   input wire logic txPosParityByte,
   output logic [63:0] serTxBus,
   output logic [7:0] alignAlarm,
   output logic [7:0] parityError
);

   // ----------------------------------------------------------------
   // register storage
   // ----------------------------------------------------------------
   byte_t outMux_r;
   fifo_level_t minThr_r;
   logic [2:0] minSpare_r;
   fifo_level_t maxThr_r;
   logic [2:0] maxSpare_r;
   byte_t testCtl_r;
   byte_t firstInj_r;
   byte_t secondInj_r;
   byte_t parMask_r;
   chan_mask_t alarmEn_r;
   chan_mask_t alignFlag_r;
   chan_mask_t intMask_r;
   chan_mask_t parFlag_r;
   chan_mask_t injPend_r;
   chan_mask_t injBusy;
   chan_mask_t alarmRaw;
   chan_mask_t parErrNow;
   logic ack_r;
   logic [31:0] rdData_r;
   logic [31:0] rdData_nxt;
   logic irq_r;

   logic busReq;
   logic wrStb;
   logic rdStb;
   logic [17:0] regIdx;
   logic loopEn;
   logic parEven;
   logic scrEn;
   burst_cnt_t burstCount;

   assign busReq = wb_cyc_i & wb_stb_i & ~ack_r;
   assign regIdx = wb_adr_i[19:2];
   // only the low byte lane carries register data
   assign wrStb = busReq & wb_we_i & wb_sel_i[0];
   assign rdStb = busReq & ~wb_we_i;
   assign loopEn = testCtl_r[`BIT_LOOP];
   assign parEven = testCtl_r[`BIT_PAR_EVEN];
   assign scrEn = testCtl_r[`BIT_SCRAMBLE];
   assign burstCount = testCtl_r[3:0];

   // ----------------------------------------------------------------
   // bus handshake: one wait cycle, ack for exactly one cycle
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= busReq;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         rdData_r <= 32'h0000_0000;
      end else if (rdStb) begin
         rdData_r <= rdData_nxt;
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdData_r;

   // ----------------------------------------------------------------
   // plain configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         outMux_r <= `RST_OUT_MUX;
      end else if (wrStb && regIdx == `IDX_OUT_MUX) begin
         outMux_r <= wb_dat_i[7:0];
      end
   end

   // both thresholds are stored as written; software keeps them in range
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         minThr_r <= `RST_MIN_THR;
         minSpare_r <= 3'h0;
      end else if (wrStb && regIdx == `IDX_MIN_THR) begin
         minThr_r <= wb_dat_i[4:0];
         minSpare_r <= 3'h0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         maxThr_r <= `RST_MAX_THR;
         maxSpare_r <= 3'h0;
      end else if (wrStb && regIdx == `IDX_MAX_THR) begin
         maxThr_r <= wb_dat_i[4:0];
         maxSpare_r <= 3'h0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         testCtl_r <= `RST_TEST_CTL;
      end else if (wrStb && regIdx == `IDX_TEST_CTL) begin
         testCtl_r <= {1'b0, wb_dat_i[6:0]};
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         firstInj_r <= `RST_INJ;
         secondInj_r <= `RST_INJ;
         parMask_r <= `RST_INJ;
      end else if (wrStb) begin
         if (regIdx == `IDX_FIRST_INJ) begin
            firstInj_r <= wb_dat_i[7:0];
         end
         if (regIdx == `IDX_SECOND_INJ) begin
            secondInj_r <= wb_dat_i[7:0];
         end
         if (regIdx == `IDX_PAR_MASK) begin
            parMask_r <= wb_dat_i[7:0];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         alarmEn_r <= 8'h00;
         intMask_r <= 8'h00;
      end else if (wrStb) begin
         if (regIdx == `IDX_ALARM_EN) begin
            alarmEn_r <= wb_dat_i[7:0];
         end
         if (regIdx == `IDX_INT_MASK) begin
            intMask_r <= wb_dat_i[7:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // sticky flags: a read clears, a new event in the same cycle wins
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         alignFlag_r <= 8'h00;
      end else if (rdStb && regIdx == `IDX_ALIGN_FLAG) begin
         alignFlag_r <= alarmRaw & alarmEn_r;
      end else begin
         alignFlag_r <= alignFlag_r | (alarmRaw & alarmEn_r);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         parFlag_r <= 8'h00;
      end else if (rdStb && regIdx == `IDX_PAR_FLAG) begin
         parFlag_r <= parErrNow;
      end else begin
         parFlag_r <= parFlag_r | parErrNow;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(alignFlag_r & intMask_r);
      end
   end

   assign irqOut = irq_r;

   // ----------------------------------------------------------------
   // read multiplexer
   // ----------------------------------------------------------------
   always_comb begin
      rdData_nxt = 32'h0000_0000;
      case (regIdx)
         `IDX_OUT_MUX: rdData_nxt[7:0] = outMux_r;
         `IDX_MIN_THR: rdData_nxt[7:0] = {minSpare_r, minThr_r};
         `IDX_MAX_THR: rdData_nxt[7:0] = {maxSpare_r, maxThr_r};
         `IDX_TEST_CTL: rdData_nxt[7:0] = testCtl_r;
         `IDX_FIRST_INJ: rdData_nxt[7:0] = firstInj_r;
         `IDX_SECOND_INJ: rdData_nxt[7:0] = secondInj_r;
         `IDX_PAR_MASK: rdData_nxt[7:0] = parMask_r;
         `IDX_INJ_CMD: rdData_nxt[7:0] = injPend_r | injBusy;
         `IDX_ALARM_EN: rdData_nxt[7:0] = alarmEn_r;
         `IDX_ALIGN_FLAG: rdData_nxt[7:0] = alignFlag_r;
         `IDX_INT_MASK: rdData_nxt[7:0] = intMask_r;
         `IDX_PAR_FLAG: rdData_nxt[7:0] = parFlag_r;
         `IDX_ALARM_RAW: rdData_nxt[7:0] = alarmRaw;
         default: rdData_nxt = 32'h0000_0000;
      endcase
   end

   // ----------------------------------------------------------------
   // scrambler keystreams, frame synchronous, one byte per clock
   // ----------------------------------------------------------------
   function automatic logic [14:0] scr_step(input scr_state_t s);
      scr_state_t st;
      byte_t ks;
      st = s;
      ks = 8'h00;
      for (int b = 7; b >= 0; b--) begin
         ks[b] = st[6];
         st = {st[5:0], st[6] ^ st[5]};
      end
      return {st, ks};
   endfunction

   scr_state_t txScr_r;
   scr_state_t rxScr_r;
   logic [14:0] txStep;
   logic [14:0] rxStep;
   byte_t txKey;
   byte_t rxKey;

   assign txStep = scr_step(txFrameStart ? `RST_SCR_SEED : txScr_r);
   assign rxStep = scr_step(rxFrameStart ? `RST_SCR_SEED : rxScr_r);
   assign txKey = scrEn ? txStep[7:0] : 8'h00;
   assign rxKey = scrEn ? rxStep[7:0] : 8'h00;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         txScr_r <= `RST_SCR_SEED;
         rxScr_r <= `RST_SCR_SEED;
      end else begin
         txScr_r <= txStep[14:8];
         rxScr_r <= rxStep[14:8];
      end
   end

   // ----------------------------------------------------------------
   // per channel datapath
   // ----------------------------------------------------------------
   byte_t rxPlain [8];
   burst_cnt_t remain_r [8];
   logic [63:0] outBus_r;
   logic [7:0] outPar_r;
   logic [63:0] serTx_r;
   chan_mask_t alarm_r;
   chan_mask_t parErr_r;

   genvar ch;
   generate
      for (ch = 0; ch < 8; ch++) begin : g_chan
         fifo_level_t lvl;
         byte_t dinByte;
         byte_t txSrc;
         byte_t txMod;
         logic loadNow;
         burst_cnt_t effRemain;

         assign lvl = alignFifoLevel[ch*5 +: 5];
         assign dinByte = parallelChannelInBus[ch*8 +: 8];
         // descramble after frame recovery
         assign rxPlain[ch] = rxFramedBus[ch*8 +: 8] ^ rxKey;
         // violation of either alignment threshold
         assign alarmRaw[ch] = (lvl < minThr_r) || (lvl > maxThr_r);
         // parallel input byte parity against the selected sense
         assign parErrNow[ch] = (^{dinByte, parallelChannelInParity[ch]}) != ~parEven;

         // a burst is armed by writing 1 and loaded at the next first framing byte
         assign loadNow = txPosFirstFraming & injPend_r[ch];
         assign effRemain = loadNow ? burstCount : remain_r[ch];
         assign injBusy[ch] = remain_r[ch] != 4'h0;

         always_ff @(posedge ref_clk) begin
            if (sys_rst) begin
               injPend_r[ch] <= 1'b0;
            end else if (wrStb && regIdx == `IDX_INJ_CMD && wb_dat_i[ch]) begin
               injPend_r[ch] <= 1'b1;
            end else if (loadNow) begin
               injPend_r[ch] <= 1'b0;
            end
         end

         always_ff @(posedge ref_clk) begin
            if (sys_rst) begin
               remain_r[ch] <= 4'h0;
            end else if (loadNow) begin
               remain_r[ch] <= burstCount;
            end else if (txPosSecondFraming && remain_r[ch] != 4'h0) begin
               remain_r[ch] <= remain_r[ch] - 4'h1;
            end
         end

         // loopback feeds framed receive data to the serializer
         assign txSrc = loopEn ? rxFramedBus[ch*8 +: 8] : dinByte;

         always_comb begin
            txMod = txSrc;
            if (txPosFirstFraming && effRemain != 4'h0) begin
               txMod = firstInj_r;
            end else if (txPosSecondFraming && remain_r[ch] != 4'h0) begin
               txMod = secondInj_r;
            end else if (txPosParityByte) begin
               txMod = txSrc ^ parMask_r;
            end
         end

         always_ff @(posedge ref_clk) begin
            if (sys_rst) begin
               serTx_r[ch*8 +: 8] <= 8'h00;
            end else begin
               serTx_r[ch*8 +: 8] <= txMod ^ txKey;
            end
         end

         always_ff @(posedge ref_clk) begin
            if (sys_rst) begin
               alarm_r[ch] <= 1'b0;
               parErr_r[ch] <= 1'b0;
            end else begin
               alarm_r[ch] <= alarmRaw[ch];
               parErr_r[ch] <= parErrNow[ch];
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // parallel output mux and output parity
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         outBus_r <= 64'h0000_0000_0000_0000;
      end else begin
         outBus_r[31:0] <= {rxPlain[3], rxPlain[2], rxPlain[1], rxPlain[0]};
         outBus_r[39:32] <= outMux_r[`BIT_MUX_B01] ? rxPlain[4] : rxPlain[5];
         outBus_r[47:40] <= rxPlain[5];
         outBus_r[55:48] <= outMux_r[`BIT_MUX_B23] ? rxPlain[6] : rxPlain[7];
         outBus_r[63:56] <= rxPlain[7];
      end
   end

   logic [63:0] outSel;
   assign outSel = {rxPlain[7], outMux_r[`BIT_MUX_B23] ? rxPlain[6] : rxPlain[7],
                    rxPlain[5], outMux_r[`BIT_MUX_B01] ? rxPlain[4] : rxPlain[5],
                    rxPlain[3], rxPlain[2], rxPlain[1], rxPlain[0]};

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         outPar_r <= 8'h00;
      end else begin
         for (int i = 0; i < 8; i++) begin
            outPar_r[i] <= (^outSel[i*8 +: 8]) ^ ~parEven;
         end
      end
   end

   assign parallelChannelOutBus = outBus_r;
   assign parallelChannelOutParity = outPar_r;
   assign serTxBus = serTx_r;
   assign alignAlarm = alarm_r;
   assign parityError = parErr_r;

endmodule

/* File: test/bp_cfg_monitor.sv */
// port checks for the channel test configuration bank
`timescale 1ns/1ps
module bp_cfg_monitor (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic irqOut,
   input wire logic [63:0] rxFramedBus,
   input wire logic [63:0] parallelChannelInBus,
   input wire logic [7:0] parallelChannelInParity,
   input wire logic [63:0] parallelChannelOutBus,
   input wire logic [7:0] parallelChannelOutParity,
   input wire logic [7:0] parityError,
   input wire logic [7:0] alignAlarm
);
   logic [7:0] inOdd;
   logic [7:0] outOdd;
   logic [31:0] rxPrev_r;
   wire logic [31:0] rxKey = parallelChannelOutBus[31:0] ^ rxPrev_r;
   wire logic busReq = wb_cyc_i & wb_stb_i;
   wire logic reqOpen = busReq & ~wb_ack_o;
   wire logic alarmAny = |alignAlarm;
   always_ff @(posedge ref_clk) begin
      rxPrev_r <= rxFramedBus[31:0];
   end
   always_comb begin
      for (int n = 0; n < 8; n++) begin
         inOdd[n] = ^{parallelChannelInBus[8*n+:8], parallelChannelInParity[n]};
         outOdd[n] = ^{parallelChannelOutBus[8*n+:8], parallelChannelOutParity[n]};
      end
   end
   // ------------------------------
   // assertions
   // ------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   sequence sReq;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence sAns;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   chk_ack_follows:
      assert property (sReq |=> sAns) else $error("request not answered by a single ack");
   chk_ack_cause:
      assert property (wb_ack_o |-> $past(reqOpen)) else $error("ack without a request");
   chk_read_upper:
      assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000) else $error("read data upper bits set");
   chk_in_parity:
      assert property (!$past(sys_rst) |-> (parityError ^ $past(inOdd)) inside {8'h00, 8'hFF})
      else $error("input parity errors differ in sense");
   chk_out_parity:
      assert property (outOdd inside {8'h00, 8'hFF}) else $error("output parity differs in sense");
   chk_rx_key:
      assert property (!$past(sys_rst) |-> rxKey == {4{rxKey[7:0]}}) else $error("receive keystream differs");
   chk_irq_fall:
      assert property ($fell(irqOut) |-> $past(busReq, 2)) else $error("interrupt dropped without access");
   chk_irq_rise:
      assert property ($rose(irqOut) |-> $past(alarmAny) || $past(alarmAny, 2) || $past(alarmAny, 3)
         || $past(busReq, 2)) else $error("interrupt raised without cause");
endmodule
bind backplane_channel_test_config bp_cfg_monitor i_mon (.ref_clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_dat_o,
   .wb_ack_o, .irqOut, .rxFramedBus, .parallelChannelInBus, .parallelChannelInParity, .parallelChannelOutBus,
   .parallelChannelOutParity, .parityError, .alignAlarm);

/* File: test/fabric_model.sv */
// fabric model driving the parallel transmit bus with parity
`timescale 1ns/1ps
module fabric_model (
   input wire logic ref_clk,
   input wire logic evenPar,
   input wire logic [7:0] flipPar,
   output logic [63:0] parallelChannelInBus,
   output logic [7:0] parallelChannelInParity
);
   logic [7:0] cnt_r = 8'h00;
   always_ff @(posedge ref_clk) begin
      cnt_r <= cnt_r + 8'h01;
   end
   // flipPar corrupts a channel's parity on purpose
   always_comb begin
      for (int n = 0; n < 8; n++) begin
         parallelChannelInBus[8*n+:8] = cnt_r ^ (8'h25 * 8'(n));
         parallelChannelInParity[n] = ^parallelChannelInBus[8*n+:8] ^ !evenPar ^ flipPar[n];
      end
   end
endmodule

/* File: test/backplane_channel_test_config_bench.sv */
// self-checking bench for the channel test configuration bank
`timescale 1ns/1ps
`include "bp_test_cfg_consts.svh"
module backplane_channel_test_config_bench;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic req = 1'b0;
   logic wb_we_i = 1'b0;
   logic [19:0] wb_adr_i = 20'h00000;
   logic [31:0] wb_dat_i = 32'h00000000;
   logic [3:0] wb_sel_i = 4'h0;
   logic [63:0] rxFramedBus = 64'h8877665544332211;
   logic rxFrameStart = 1'b0;
   logic [39:0] alignFifoLevel = {8{5'h0A}};
   logic [3:0] txPos = 4'h0;
   logic [7:0] flipPar = 8'h00;
   logic [31:0] wb_dat_o, q;
   logic wb_ack_o, irqOut;
   logic [63:0] parallelChannelInBus, parallelChannelOutBus, serTxBus, src, got;
   logic [7:0] parallelChannelInParity, parallelChannelOutParity, alignAlarm, parityError;
   int mismatches = 0;
   int checks = 0;
   initial begin
      forever #2.5 ref_clk = ~ref_clk;
   end
   backplane_channel_test_config i_dut (.ref_clk, .sys_rst, .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irqOut, .rxFramedBus, .rxFrameStart, .alignFifoLevel,
      .parallelChannelInBus, .parallelChannelInParity, .parallelChannelOutBus, .parallelChannelOutParity,
      .txFrameStart(txPos[0]), .txPosFirstFraming(txPos[1]), .txPosSecondFraming(txPos[2]),
      .txPosParityByte(txPos[3]), .serTxBus, .alignAlarm, .parityError);
   fabric_model i_fab (.ref_clk, .evenPar(1'b1), .flipPar, .parallelChannelInBus, .parallelChannelInParity);
   // ------------------------------
   // helpers
   // ------------------------------
   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wb(input logic w, input logic [17:0] idx, input logic [7:0] d);
      @(posedge ref_clk);
      req <= 1'b1;
      wb_we_i <= w;
      wb_sel_i <= 4'hF;
      wb_adr_i <= {idx, 2'b00};
      wb_dat_i <= {24'h000000, d};
      // the wait ends on the ack; only the watchdog ends a wait that gets none
      do begin
         @(posedge ref_clk);
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      req <= 1'b0;
      wb_sel_i <= 4'h0;
   endtask
   task automatic rd(input logic [17:0] idx, input logic [7:0] e);
      wb(1'b0, idx, 8'h00);
      chk(q, e);
   endtask
   task automatic tx(input logic [3:0] p);
      @(posedge ref_clk);
      txPos <= p;
      @(negedge ref_clk);
      src = parallelChannelInBus;
      @(posedge ref_clk);
      txPos <= 4'h0;
      @(negedge ref_clk);
      got = serTxBus;
   endtask
   task automatic lvl(input logic [4:0] a, input logic [4:0] b);
      @(posedge ref_clk);
      alignFifoLevel <= {{6{5'h0A}}, b, a};
      repeat (5) @(negedge ref_clk);
   endtask
   // ------------------------------
   // scenarios
   // ------------------------------
   task automatic t_regs();
      logic [17:0] ix [7] = '{`IDX_OUT_MUX, `IDX_MIN_THR, `IDX_MAX_THR, `IDX_TEST_CTL, `IDX_FIRST_INJ,
         `IDX_SECOND_INJ, `IDX_PAR_MASK};
      logic [7:0] rv [7] = '{8'hFF, 8'h02, 8'h0F, 8'h60, 8'h00, 8'h00, 8'h00};
      for (int i = 0; i < 7; i++) begin
         rd(ix[i], rv[i]);
         wb(1'b1, ix[i], 8'h15);
         rd(ix[i], 8'h15);
         wb(1'b1, ix[i], rv[i]);
      end
      wb(1'b1, 18'h30001, 8'h5A);
      rd(18'h30001, 8'h00);
      $display("register test done");
   endtask
   task automatic t_mux();
      logic [7:0] s [4] = '{8'hFF, 8'hBF, 8'h7F, 8'h3F};
      logic [7:0] e4, e6;
      wb(1'b1, `IDX_TEST_CTL, 8'h20);
      for (int i = 0; i < 4; i++) begin
         wb(1'b1, `IDX_OUT_MUX, s[i]);
         repeat (2) @(negedge ref_clk);
         e4 = s[i][6] ? rxFramedBus[39:32] : rxFramedBus[47:40];
         e6 = s[i][7] ? rxFramedBus[55:48] : rxFramedBus[63:56];
         chk({parallelChannelOutBus[55:48], parallelChannelOutBus[39:0]}, {e6, e4, rxFramedBus[31:0]});
      end
      wb(1'b1, `IDX_TEST_CTL, 8'h60);
      @(posedge ref_clk);
      rxFrameStart <= 1'b1;
      @(posedge ref_clk);
      rxFrameStart <= 1'b0;
      @(negedge ref_clk);
      // first keystream byte after a reseed to all ones is FE
      chk(parallelChannelOutBus[31:0], rxFramedBus[31:0] ^ {4{8'hFE}});
      tx(4'h1);
      chk(got, src ^ {8{8'hFE}});
      wb(1'b1, `IDX_TEST_CTL, 8'h30);
      tx(4'h0);
      chk(got, rxFramedBus);
      wb(1'b1, `IDX_TEST_CTL, 8'h20);
      tx(4'h0);
      chk(got, src);
      $display("mux and loopback test done");
   endtask
   task automatic t_inject();
      wb(1'b1, `IDX_TEST_CTL, 8'h22);
      wb(1'b1, `IDX_FIRST_INJ, 8'h5A);
      wb(1'b1, `IDX_SECOND_INJ, 8'hC3);
      wb(1'b1, `IDX_INJ_CMD, 8'h01);
      for (int f = 0; f < 3; f++) begin
         tx(4'h3);
         chk(got[15:0], {src[15:8], f < 2 ? 8'h5A : src[7:0]});
         tx(4'h4);
         chk(got[15:0], {src[15:8], f < 2 ? 8'hC3 : src[7:0]});
      end
      for (int m = 0; m < 2; m++) begin
         wb(1'b1, `IDX_PAR_MASK, m ? 8'h81 : 8'h00);
         tx(4'h8);
         chk(got, src ^ {8{m ? 8'h81 : 8'h00}});
      end
      $display("injection test done");
   endtask
   task automatic t_align();
      wb(1'b1, `IDX_MIN_THR, 8'h05);
      wb(1'b1, `IDX_MAX_THR, 8'h14);
      wb(1'b1, `IDX_ALARM_EN, 8'hFF);
      wb(1'b1, `IDX_INT_MASK, 8'h01);
      lvl(5'h05, 5'h14);
      chk({irqOut, alignAlarm}, 9'h000);
      lvl(5'h04, 5'h15);
      chk({irqOut, alignAlarm}, 9'h103);
      lvl(5'h0A, 5'h0A);
      rd(`IDX_ALIGN_FLAG, 8'h03);
      repeat (3) @(negedge ref_clk);
      chk(irqOut, 1'b0);
      lvl(5'h0A, 5'h15);
      lvl(5'h0A, 5'h0A);
      chk(irqOut, 1'b0);
      rd(`IDX_ALIGN_FLAG, 8'h02);
      $display("alignment alarm test done");
   endtask
   task automatic t_parity();
      rd(`IDX_PAR_FLAG, 8'hFF);
      @(posedge ref_clk);
      flipPar <= 8'h04;
      repeat (3) @(negedge ref_clk);
      chk(parityError, 8'h04);
      chk(^{parallelChannelOutBus[7:0], parallelChannelOutParity[0]}, 1'b0);
      wb(1'b1, `IDX_TEST_CTL, 8'h00);
      repeat (3) @(negedge ref_clk);
      chk(parityError, 8'hFB);
      chk(^{parallelChannelOutBus[7:0], parallelChannelOutParity[0]}, 1'b1);
      @(posedge ref_clk);
      flipPar <= 8'h00;
      wb(1'b1, `IDX_TEST_CTL, 8'h20);
      rd(`IDX_PAR_FLAG, 8'hFF);
      rd(`IDX_PAR_FLAG, 8'h00);
      $display("parity test done");
   endtask
   task automatic end_sim();
      $display("counts: %0d checks, %0d mismatches", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge ref_clk);
      sys_rst <= 1'b0;
      t_regs();
      t_mux();
      t_inject();
      t_align();
      t_parity();
      end_sim();
   end
   initial begin
      #100000;
      mismatches++;
      end_sim();
   end
endmodule
